// ==== include/pls_map.vh ====
// Purpose: constants for the synthesiser core
// Assumes: 10 MHz system clock
// Notes: times in ns, counts derived in cycles
`ifndef PLS_MAP_VH
`define PLS_MAP_VH
`define PLS_CLK_NS 100
`define PLS_REF_DIV 4
`define PLS_MOD_HI 16
`define PLS_MOD_LO 15
`define PLS_ZERO_PULSE_NS 30
// longest time rounds down, but never below one cycle
`define PLS_ZERO_PULSE_CYC ((`PLS_ZERO_PULSE_NS / `PLS_CLK_NS) < 1 ? 1 : \
    (`PLS_ZERO_PULSE_NS / `PLS_CLK_NS))
`define PLS_OSC_RST 2'h0
`define PLS_CNT_RST 4'h0
`endif

// ==== src/pls_pfd.v ====
// Purpose: phase/frequency comparator on falling edges
// Assumes: inputs already synchronised to i_clk
// Notes: outputs registered
`timescale 1ns/1ps
module pls_pfd (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ref,
    input wire i_fb,
    output reg o_pump_dn_n,
    output reg o_pump_up
);
    reg ref_d_r;
    reg fb_d_r;
    reg lead_r;
    reg lag_r;
    wire ref_fall;
    wire fb_fall;
    reg lead_nxt;
    reg lag_nxt;

    assign ref_fall = ref_d_r & ~i_ref;
    assign fb_fall = fb_d_r & ~i_fb;

    // ------------------------------------------------------------
    // lead/lag state
    // ------------------------------------------------------------
    // coincident edges leave both idle, so no residual pulse at zero phase
    always @* begin
        lead_nxt = lead_r;
        lag_nxt = lag_r;
        if (ref_fall && fb_fall) begin
            lead_nxt = 1'b0;
            lag_nxt = 1'b0;
        end else if (ref_fall) begin
            if (lag_r) begin
                lag_nxt = 1'b0;
            end else begin
                lead_nxt = 1'b1;
            end
        end else if (fb_fall) begin
            if (lead_r) begin
                lead_nxt = 1'b0;
            end else begin
                lag_nxt = 1'b1;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_d_r <= 1'b1;
            fb_d_r <= 1'b1;
            lead_r <= 1'b0;
            lag_r <= 1'b0;
            o_pump_dn_n <= 1'b1;
            o_pump_up <= 1'b0;
        end else begin
            ref_d_r <= i_ref;
            fb_d_r <= i_fb;
            lead_r <= lead_nxt;
            lag_r <= lag_nxt;
            // pulse width tracks edge spacing
            o_pump_dn_n <= ~lead_nxt;
            o_pump_up <= lag_nxt;
        end
    end
endmodule

// ==== src/pls_synth_core.v ====
// Purpose: synthesiser core: reference divider, comparator, 16/15 prescaler
// Assumes: all pins sampled on I_MCLK; pin rates well below 5 MHz
// Notes: analog oscillator, pump and filter are outside
//        pump outputs are registered inside the comparator module
`timescale 1ns/1ps
`include "pls_map.vh"
module pls_synth_core #(
    parameter CNT_W = 4
) (
    input wire I_MCLK,
    input wire I_RSTN,
    input wire i_OSC,
    input wire i_CMP_REF,
    input wire i_CMP_FB,
    input wire i_PRE_CLK,
    input wire i_MOD_HI,
    output reg o_REF_DIV4,
    output wire o_PUMP_DN_N,
    output wire o_PUMP_UP,
    output reg o_PRE_OUT
);

    // ------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------
    // wrap points of the prescaler counter, which runs from zero up to
    // and including the wrap point
    localparam integer TOP16_I = `PLS_MOD_HI - 1;
    localparam integer TOP15_I = `PLS_MOD_LO - 1;
    localparam [CNT_W-1:0] TOP16 = TOP16_I[CNT_W-1:0];
    localparam [CNT_W-1:0] TOP15 = TOP15_I[CNT_W-1:0];

    // one gate, but kept as a function so every edge in the block is found
    // the same way
    function rise_of;
        input now_v;
        input prev_v;
        begin
            rise_of = now_v & ~prev_v;
        end
    endfunction

    // wrap point for the next cycle, picked by the modulus control level;
    // high selects the longer cycle
    function [CNT_W-1:0] top_of;
        input mod_hi_v;
        begin
            if (mod_hi_v) begin
                top_of = TOP16;
            end else begin
                top_of = TOP15;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] osc_s_r;
    reg [1:0] ref_s_r;
    reg [1:0] fb_s_r;
    reg [1:0] pck_s_r;
    reg [1:0] mod_s_r;
    // every pin crosses into I_MCLK through two flops; a pin that moves
    // faster than about half of I_MCLK is lost, which bounds all pin rates
    // comparator pins reset high, their idle level, so that release of
    // reset cannot look like a falling edge and start a pump pulse
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            osc_s_r <= 2'h0;
            ref_s_r <= 2'h3;
            fb_s_r <= 2'h3;
            pck_s_r <= 2'h0;
            mod_s_r <= 2'h3;
        end else begin
            osc_s_r <= {osc_s_r[0], i_OSC};
            ref_s_r <= {ref_s_r[0], i_CMP_REF};
            fb_s_r <= {fb_s_r[0], i_CMP_FB};
            pck_s_r <= {pck_s_r[0], i_PRE_CLK};
            mod_s_r <= {mod_s_r[0], i_MOD_HI};
        end
    end

    // ------------------------------------------------------------
    // reference divide by four
    // ------------------------------------------------------------
    // the oscillator edge is found after the synchroniser, so it costs one
    // extra flop of delay but never sees a half-settled level
    reg osc_d_r;
    reg [1:0] osc_cnt_r;
    reg [1:0] osc_cnt_nxt;
    reg ref_div_nxt;

    wire osc_rise;

    assign osc_rise = rise_of(osc_s_r[1], osc_d_r);

    // top bit of an edge counter is the quarter-rate square wave, so no
    // separate toggle flop has to be kept in step with the count
    always @* begin
        osc_cnt_nxt = osc_cnt_r;
        if (osc_rise) begin
            osc_cnt_nxt = osc_cnt_r + 2'h1;
        end
        ref_div_nxt = osc_cnt_nxt[1];
    end

    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            osc_d_r <= 1'b0;
            osc_cnt_r <= `PLS_OSC_RST;
            o_REF_DIV4 <= 1'b0;
        end else begin
            osc_d_r <= osc_s_r[1];
            osc_cnt_r <= osc_cnt_nxt;
            o_REF_DIV4 <= ref_div_nxt;
        end
    end

    // ------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------
    // edges reach the comparator two clocks after the pin moves, the same
    // delay on both inputs, so the pulse width keeps the true edge spacing
    pls_pfd pls_pfd_inst (
        .i_clk(I_MCLK),
        .i_rst_n(I_RSTN),
        .i_ref(ref_s_r[1]),
        .i_fb(fb_s_r[1]),
        .o_pump_dn_n(o_PUMP_DN_N),
        .o_pump_up(o_PUMP_UP)
    );

    // ------------------------------------------------------------
    // two-modulus prescaler
    // ------------------------------------------------------------
    // modulus is sampled at the end of each cycle so a counter clocked on the
    // output fall has the rest of the output period, from the fall to the wrap, to settle
    // output phase, one-hot: high from wrap to mid-cycle, low for the rest
    localparam [1:0] ST_HIGH = 2'b01;
    localparam [1:0] ST_LOW = 2'b10;

    reg pck_d_r;
    reg [CNT_W-1:0] pre_cnt_r;
    reg [CNT_W-1:0] pre_cnt_nxt;
    reg [CNT_W-1:0] pre_top_r;
    reg [CNT_W-1:0] pre_top_nxt;
    reg [1:0] pre_st_r;
    reg [1:0] pre_st_nxt;
    reg pre_out_nxt;

    wire pck_rise;
    wire pre_wrap;
    wire pre_half;

    assign pck_rise = rise_of(pck_s_r[1], pck_d_r);
    assign pre_wrap = pck_rise && (pre_cnt_r >= pre_top_r);
    // half of the wrap point: the fall comes eight input rises after the
    // wrap in either modulus
    assign pre_half = pck_rise && (pre_cnt_r == {1'b0, pre_top_r[CNT_W-1:1]});

    always @* begin
        pre_cnt_nxt = pre_cnt_r;
        pre_top_nxt = pre_top_r;
        pre_st_nxt = pre_st_r;
        // >= rather than == keeps the counter from running away if it ever
        // holds a value past the wrap point
        if (pre_wrap) begin
            pre_cnt_nxt = `PLS_CNT_RST;
            pre_top_nxt = top_of(mod_s_r[1]);
        end else if (pck_rise) begin
            pre_cnt_nxt = pre_cnt_r + 1'b1;
        end
        // falls mid-cycle; outside counter steps on this edge and has the
        // rest of the cycle before the next wrap samples the control
        case (pre_st_r)
            ST_HIGH: begin
                if (pre_half && !pre_wrap) begin
                    pre_st_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (pre_wrap) begin
                    pre_st_nxt = ST_HIGH;
                end
            end
            default: begin
                pre_st_nxt = ST_HIGH;
            end
        endcase
        pre_out_nxt = pre_st_nxt[0];
    end

    // o_PRE_OUT is loaded from the next-state decode so it leaves a flop
    // directly with no gate after it
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pck_d_r <= 1'b0;
            pre_cnt_r <= `PLS_CNT_RST;
            pre_top_r <= TOP16;
            pre_st_r <= ST_HIGH;
            o_PRE_OUT <= 1'b1;
        end else begin
            pck_d_r <= pck_s_r[1];
            pre_cnt_r <= pre_cnt_nxt;
            pre_top_r <= pre_top_nxt;
            pre_st_r <= pre_st_nxt;
            o_PRE_OUT <= pre_out_nxt;
        end
    end
endmodule

// ==== verif/pls_synth_core_sva.sv ====
// Purpose: pin-level assertions for the synthesiser core
// Assumes: pin edges at least four cycles apart on each pin
// Notes: pump outputs move three cycles after the pin edge
`timescale 1ns/1ps
module pls_synth_core_sva (
    input wire I_MCLK,
    input wire I_RSTN,
    input wire i_CMP_REF,
    input wire i_CMP_FB,
    input wire i_PRE_CLK,
    input wire o_REF_DIV4,
    input wire o_PUMP_DN_N,
    input wire o_PUMP_UP,
    input wire o_PRE_OUT
);
    reg [3:0] low_cnt_r;
    wire idle = o_PUMP_DN_N && !o_PUMP_UP;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // pin rises seen while the prescaler output is low
    always @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN)
            low_cnt_r <= 4'h0;
        else if ($fell(o_PRE_OUT))
            low_cnt_r <= 4'h0;
        else if ($rose(i_PRE_CLK))
            low_cnt_r <= low_cnt_r + 4'h1;
    end
    ref_div_a: assert property ($changed(o_REF_DIV4) |=> $stable(o_REF_DIV4) [*7])
        else $error("divided reference toggled too soon");
    rise_ignored_a: assert property ($rose(i_CMP_REF) && idle && $stable(i_CMP_FB) |-> ##3 idle)
        else $error("rising edge moved a pump");
    ref_lead_a: assert property ($fell(i_CMP_REF) && idle && $stable(i_CMP_FB)
        |-> ##3 !o_PUMP_DN_N && !o_PUMP_UP) else $error("no down pulse");
    fb_lead_a: assert property ($fell(i_CMP_FB) && idle && $stable(i_CMP_REF)
        |-> ##3 o_PUMP_UP && o_PUMP_DN_N) else $error("no up pulse");
    dn_hold_a: assert property ($stable(i_CMP_FB) [*4] ##0 !o_PUMP_DN_N |=> !o_PUMP_DN_N)
        else $error("down pulse ended early");
    zero_phase_a: assert property ($fell(i_CMP_REF) && $fell(i_CMP_FB) && idle |=> idle [*3])
        else $error("residual pulse on aligned edges");
    pulse_end_a: assert property (!o_PUMP_DN_N && $fell(i_CMP_FB) |-> ##3 idle)
        else $error("down pulse did not end");
    pre_low_a: assert property ($rose(o_PRE_OUT) |-> low_cnt_r == 4'h7 || low_cnt_r == 4'h8)
        else $error("prescaler low phase wrong length");
    cover property ($fell(o_PUMP_DN_N));
    cover property ($rose(o_PUMP_UP));
    cover property ($rose(o_PRE_OUT) && low_cnt_r == 4'h7);
endmodule
bind pls_synth_core pls_synth_core_sva pls_synth_core_sva_inst (.I_MCLK, .I_RSTN, .i_CMP_REF,
    .i_CMP_FB, .i_PRE_CLK, .o_REF_DIV4, .o_PUMP_DN_N, .o_PUMP_UP, .o_PRE_OUT);

// ==== verif/pls_ext_cnt.sv ====
// Purpose: outside counter steering the prescaler modulus
// Assumes: one divide-by-15 cycle in every four prescaler cycles
// Notes: fixed mode holds the control high
`timescale 1ns/1ps
module pls_ext_cnt (
    input wire i_rst_n,
    input wire i_pre_out,
    input wire i_fixed,
    output wire o_mod_hi
);
    reg [1:0] cnt_r;
    // clocked by the slow prescaler output, so it never sees the fast input clock
    always @(negedge i_pre_out or negedge i_rst_n) begin
        if (!i_rst_n)
            cnt_r <= 2'h0;
        else
            cnt_r <= cnt_r + 2'h1;
    end
    assign o_mod_hi = i_fixed || cnt_r != 2'h0;
endmodule

// ==== verif/pls_synth_core_bench.sv ====
// Purpose: self-checking bench for the synthesiser core
// Assumes: oscillator and prescaler pins run at a six-cycle period
// Notes: spans are measured in system clock cycles
`timescale 1ns/1ps
module pls_synth_core_bench;
    reg I_MCLK = 1'b0;
    reg I_RSTN = 1'b0;
    reg i_OSC = 1'b0;
    reg i_CMP_REF = 1'b1;
    reg i_CMP_FB = 1'b1;
    reg i_PRE_CLK = 1'b0;
    reg fixed = 1'b1;
    reg [2:0] ph = 3'h0;
    wire i_MOD_HI, o_REF_DIV4, o_PUMP_DN_N, o_PUMP_UP, o_PRE_OUT;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    pls_synth_core pls_synth_core_inst (.I_MCLK, .I_RSTN, .i_OSC, .i_CMP_REF, .i_CMP_FB,
        .i_PRE_CLK, .i_MOD_HI, .o_REF_DIV4, .o_PUMP_DN_N, .o_PUMP_UP, .o_PRE_OUT);
    pls_ext_cnt pls_ext_cnt_inst (.i_rst_n(I_RSTN), .i_pre_out(o_PRE_OUT), .i_fixed(fixed),
        .o_mod_hi(i_MOD_HI));
    always #50 I_MCLK = ~I_MCLK;
    always @(posedge I_MCLK) begin
        #1;
        cyc = cyc + 1;
        ph = (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        i_OSC = ph < 3'h3;
        i_PRE_CLK = ph < 3'h3;
        if (cyc == 5000) begin
            num_errors++;
            stop_test;
        end
    end
    task stop_test;
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", nm, e, s);
        end
    endtask
    task step;
        @(posedge I_MCLK);
        #1;
    endtask
    task t_div;
        int t;
        @(posedge o_REF_DIV4);
        t = cyc;
        @(posedge o_REF_DIV4);
        chk("reference period", 16'(cyc - t), 16'h18);
    endtask
    task t_pre(input logic fx, input logic [15:0] e);
        int t;
        step;
        fixed = fx;
        repeat (2) @(posedge o_PRE_OUT);
        t = cyc;
        repeat (4) @(posedge o_PRE_OUT);
        chk("prescaler span", 16'(cyc - t), e);
    endtask
    task t_pump(input logic a, input int gap);
        int k, n, m;
        n = 0;
        m = 0;
        for (k = 0; k < gap + 14; k++) begin
            step;
            i_CMP_REF = a ? (k >= gap + 4) : (k < gap || k >= gap + 6);
            i_CMP_FB = a ? (k < gap || k >= gap + 6) : (k >= gap + 4);
            n += !o_PUMP_DN_N;
            m += o_PUMP_UP;
        end
        chk("down pulse", 16'(n), 16'(a ? gap : 0));
        chk("up pulse", 16'(m), 16'(a ? 0 : gap));
    endtask
    initial begin
        repeat (20) @(posedge I_MCLK);
        #1;
        I_RSTN = 1'b1;
        repeat (4) step;
        t_div;
        t_pre(1'b1, 16'h180);
        t_pre(1'b0, 16'h17a);
        t_pump(1'b1, 5);
        t_pump(1'b0, 9);
        t_pump(1'b1, 0);
        stop_test;
    end
endmodule
